// [verilog/ssf_consts.vh]
// shared constants for the synchronous serial frame sequencer
`ifndef SSF_CONSTS_VH
`define SSF_CONSTS_VH

`define SSF_DATA_W 16
`define SSF_FIFO_DEPTH 4
`define SSF_FIFO_AW 2
`define SSF_MIN_MSB 4'h3
`define SSF_MIN_HALF_PRESCALE 7'h01
`define SSF_FMT_SPI 1'b0
`define SSF_FMT_PULSED 1'b1
`define SSF_CORE_CLK_MHZ 200
`define SSF_RST_SCLK 1'b0
`define SSF_RST_FSS 1'b1
`define SSF_RST_TX 1'b0
`define SSF_RST_OE_N 1'b1

`endif

// [verilog/ssf_fifo.v]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.vh"
module ssf_fifo #(
    parameter WIDTH = `SSF_DATA_W,
    parameter DEPTH = `SSF_FIFO_DEPTH,
    parameter AW = `SSF_FIFO_AW
)(
    input wire core_clk,
    input wire rstn,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] cnt_q;
    reg [AW:0] cnt_d;
    reg in_ready_q;
    wire push;
    wire pop;
    localparam [AW:0] FULL = DEPTH[AW:0];

    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign in_ready = in_ready_q;
    assign push = in_valid & in_ready_q;
    assign pop = out_ready & out_valid;
    assign out_data = mem[rd_ptr_q];

    always @*
    begin
        cnt_d = cnt_q;
        if (push & ~pop)
            cnt_d = cnt_q + 1'b1;
        else if (pop & ~push)
            cnt_d = cnt_q - 1'b1;
    end

    // depth must be a power of two so the pointers wrap by themselves
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            in_ready_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d != FULL);
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

    always @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr_q] <= in_data;
    end
endmodule
`default_nettype wire

// [verilog/ssf_core.v]
// frame sequencer for pulsed-frame and spi serial formats, master end
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.vh"
module ssf_core #(
    parameter FIFO_DEPTH = `SSF_FIFO_DEPTH,
    parameter FIFO_AW = `SSF_FIFO_AW
)(
    input wire core_clk,
    input wire rstn,
    input wire port_enable,
    input wire master_mode,
    input wire frame_format,
    input wire clock_polarity_bit,
    input wire clock_phase_bit,
    input wire [3:0] word_size_m1,
    input wire [7:0] clock_prescale_divisor,
    input wire [7:0] clock_rate_field,
    input wire [`SSF_DATA_W-1:0] tx_data,
    input wire tx_valid,
    output wire tx_ready,
    output wire [`SSF_DATA_W-1:0] rx_data,
    output wire rx_valid,
    output wire busy,
    output wire serial_clock_line_o,
    output wire serial_clock_line_oe_n,
    output wire frame_select_line_o,
    output wire serial_transmit_line_o,
    output wire serial_transmit_line_oe_n,
    input wire serial_receive_line_i
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_GAP = 2'b10;

    function [3:0] eff_msb;
        input [3:0] m;
        begin
            eff_msb = (m < `SSF_MIN_MSB) ? `SSF_MIN_MSB : m;
        end
    endfunction

    // half serial period in core clocks; prescale is even, so halve it first
    function [15:0] half_count;
        input [7:0] cp;
        input [7:0] rate;
        reg [6:0] h;
        begin
            h = (cp[7:1] == 7'h00) ? `SSF_MIN_HALF_PRESCALE : cp[7:1];
            half_count = h * ({1'b0, rate} + 9'h001);
        end
    endfunction

    function [15:0] low_mask;
        input [3:0] m;
        begin
            low_mask = 16'hffff >> (4'hf - m);
        end
    endfunction

    reg [1:0] state_q;
    reg [5:0] step_q;
    reg [15:0] div_q;
    reg more_q;
    reg [15:0] tx_word_q;
    reg [15:0] rx_sh_q;
    reg rx_s1_q;
    reg rx_s2_q;
    reg [15:0] rx_data_q;
    reg rx_valid_q;
    reg busy_q;
    reg sclk_q;
    reg sclk_oe_n_q;
    reg fss_q;
    reg tx_q;
    reg tx_oe_n_q;

    wire [15:0] fifo_data;
    wire fifo_valid;
    wire pop;
    wire pulsed;
    wire [3:0] msb;
    wire [5:0] n2;
    wire [5:0] n2m1;
    wire [5:0] n2m2;
    wire [5:0] n2p1;
    wire [5:0] n2p2;
    wire [15:0] half_m1;
    wire tick;
    wire [3:0] bit_idx;
    wire cur_bit;
    wire start;
    wire reload_spi;
    wire reload_pulsed;
    wire spi_toggle;

    assign pulsed = (frame_format == `SSF_FMT_PULSED);
    assign msb = eff_msb(word_size_m1);
    assign n2 = {1'b0, msb, 1'b0} + 6'h02;
    assign n2m1 = n2 - 6'h01;
    assign n2m2 = n2 - 6'h02;
    assign n2p1 = n2 + 6'h01;
    assign n2p2 = n2 + 6'h02;
    assign half_m1 = half_count(clock_prescale_divisor, clock_rate_field) - 16'h0001;
    assign tick = (div_q == half_m1);
    // msb first: pulsed data starts at step 2, spi data at step 0
    assign bit_idx = pulsed ? (msb + 4'h1 - step_q[4:1]) : (msb - step_q[4:1]);
    assign cur_bit = tx_word_q[bit_idx];

    assign start = (state_q == ST_IDLE) & port_enable & master_mode & fifo_valid;
    assign reload_spi = (state_q == ST_RUN) & tick & ~pulsed & clock_phase_bit
        & (step_q == n2) & port_enable & fifo_valid;
    assign reload_pulsed = (state_q == ST_RUN) & tick & pulsed & (step_q == n2p2) & more_q;
    assign pop = start | reload_spi | reload_pulsed;
    // phase 1 toggles from the first half tick; phase 0 waits one half for data
    assign spi_toggle = clock_phase_bit ? (step_q <= n2m1)
        : ((step_q != 6'h00) & (step_q <= n2));

    assign rx_data = rx_data_q;
    assign rx_valid = rx_valid_q;
    assign busy = busy_q;
    assign serial_clock_line_o = sclk_q;
    assign serial_clock_line_oe_n = sclk_oe_n_q;
    assign frame_select_line_o = fss_q;
    assign serial_transmit_line_o = tx_q;
    assign serial_transmit_line_oe_n = tx_oe_n_q;

    ssf_fifo #(
        .WIDTH(`SSF_DATA_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(pop)
    );

    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            state_q <= ST_IDLE;
            step_q <= 6'h00;
            div_q <= 16'h0000;
            more_q <= 1'b0;
            tx_word_q <= 16'h0000;
            rx_sh_q <= 16'h0000;
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
            rx_data_q <= 16'h0000;
            rx_valid_q <= 1'b0;
            busy_q <= 1'b0;
            sclk_q <= `SSF_RST_SCLK;
            sclk_oe_n_q <= `SSF_RST_OE_N;
            fss_q <= `SSF_RST_FSS;
            tx_q <= `SSF_RST_TX;
            tx_oe_n_q <= `SSF_RST_OE_N;
        end
        else
        begin
            // receive pin crosses in from the outside world
            // two-clock delay: receive needs a half period of three clocks or more
            rx_s1_q <= serial_receive_line_i;
            rx_s2_q <= rx_s1_q;
            rx_valid_q <= 1'b0;
            sclk_oe_n_q <= ~master_mode;
            if ((state_q == ST_IDLE) || tick)
                div_q <= 16'h0000;
            else
                div_q <= div_q + 16'h0001;
            case (state_q)
                ST_IDLE:
                begin
                    busy_q <= 1'b0;
                    more_q <= 1'b0;
                    tx_q <= 1'b0;
                    tx_oe_n_q <= 1'b1;
                    if (pulsed)
                    begin
                        sclk_q <= 1'b0;
                        fss_q <= 1'b0;
                    end
                    else
                    begin
                        sclk_q <= clock_polarity_bit;
                        fss_q <= 1'b1;
                    end
                    if (start)
                    begin
                        tx_word_q <= fifo_data;
                        busy_q <= 1'b1;
                        state_q <= ST_RUN;
                        if (pulsed)
                        begin
                            // pulse starts on a rising edge, lasts a full period
                            sclk_q <= 1'b1;
                            fss_q <= 1'b1;
                            step_q <= 6'h01;
                        end
                        else
                        begin
                            fss_q <= 1'b0;
                            tx_oe_n_q <= 1'b0;
                            step_q <= 6'h00;
                        end
                    end
                end
                ST_RUN:
                begin
                    if (tick && pulsed)
                    begin
                        if (step_q <= n2p1)
                            sclk_q <= ~sclk_q;
                        if (!step_q[0] && (step_q >= 6'h02) && (step_q <= n2))
                        begin
                            tx_q <= cur_bit;
                            tx_oe_n_q <= 1'b0;
                        end
                        if (step_q == 6'h02)
                            fss_q <= 1'b0;
                        // next word pending: pulse again during the lsb period
                        if ((step_q == n2) && port_enable && fifo_valid)
                        begin
                            fss_q <= 1'b1;
                            more_q <= 1'b1;
                        end
                        if (step_q[0] && (step_q >= 6'h03))
                            rx_sh_q <= {rx_sh_q[14:0], rx_s2_q};
                        if (step_q == n2p2)
                        begin
                            rx_data_q <= rx_sh_q & low_mask(msb);
                            rx_valid_q <= 1'b1;
                            more_q <= 1'b0;
                            if (more_q)
                            begin
                                tx_word_q <= fifo_data;
                                tx_q <= fifo_data[msb];
                                fss_q <= 1'b0;
                                sclk_q <= 1'b1;
                                step_q <= 6'h03;
                            end
                            else
                            begin
                                tx_oe_n_q <= 1'b1;
                                tx_q <= 1'b0;
                                state_q <= ST_IDLE;
                            end
                        end
                        else
                            step_q <= step_q + 6'h01;
                    end
                    else if (tick)
                    begin
                        if (spi_toggle)
                            sclk_q <= ~sclk_q;
                        if (!step_q[0] && (step_q <= n2m2))
                            tx_q <= cur_bit;
                        if (step_q[0] && (step_q <= n2m1))
                            rx_sh_q <= {rx_sh_q[14:0], rx_s2_q};
                        if (step_q == n2m1)
                        begin
                            rx_data_q <= {rx_sh_q[14:0], rx_s2_q} & low_mask(msb);
                            rx_valid_q <= 1'b1;
                        end
                        if (reload_spi)
                        begin
                            // continuous clock, select stays low
                            tx_word_q <= fifo_data;
                            tx_q <= fifo_data[msb];
                            sclk_q <= ~sclk_q;
                            step_q <= 6'h01;
                        end
                        else if (step_q == n2p1)
                        begin
                            // phase 0 always lands here, forcing a select pulse
                            fss_q <= 1'b1;
                            tx_q <= 1'b0;
                            tx_oe_n_q <= 1'b1;
                            state_q <= ST_GAP;
                        end
                        else
                            step_q <= step_q + 6'h01;
                    end
                end
                ST_GAP:
                begin
                    // select held high at least half a period between frames
                    if (tick)
                        state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [test/ssff_monitor.sv]
// port checker for the serial frame sequencer
`timescale 1ns/1ps
`default_nettype none
module ssff_monitor (
    input wire core_clk,
    input wire rstn,
    input wire master_mode,
    input wire frame_format,
    input wire clock_polarity_bit,
    input wire clock_phase_bit,
    input wire [7:0] clock_prescale_divisor,
    input wire [7:0] clock_rate_field,
    input wire rx_valid,
    input wire busy,
    input wire serial_clock_line_o,
    input wire serial_clock_line_oe_n,
    input wire frame_select_line_o,
    input wire serial_transmit_line_o,
    input wire serial_transmit_line_oe_n
);
    wire sc = serial_clock_line_o;
    wire fs = frame_select_line_o;
    wire fmt = frame_format;
    // half serial period in core clocks; prescale bit0 ignored, below 2 acts as 2
    wire [15:0] hp = (clock_prescale_divisor[7:1] == 7'h00 ? 16'h0001
        : {9'h000, clock_prescale_divisor[7:1]}) * ({8'h00, clock_rate_field} + 16'h0001);
    logic [15:0] hi_q;
    logic [15:0] age_q;
    logic sc_q;
    always @(posedge core_clk)
    begin
        hi_q <= (!rstn || !fs) ? 16'h0000 : hi_q + 16'h0001;
        age_q <= (!rstn || sc != sc_q) ? 16'h0001 : age_q + 16'h0001;
        sc_q <= sc;
    end
    default clocking mcb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    pad_enable_a: assert property (
        $past(rstn) |-> serial_clock_line_oe_n == !$past(master_mode)) else $error("clock pad");
    spi_idle_a: assert property (
        !busy && $past(!busy) && $past(rstn) && !fmt && $stable(fmt) && $stable(clock_polarity_bit)
        |-> sc == clock_polarity_bit && fs && !serial_transmit_line_o) else $error("spi idle");
    pulsed_idle_a: assert property (
        !busy && $past(!busy) && $past(rstn) && fmt && $stable(fmt)
        |-> !sc && !fs && serial_transmit_line_oe_n) else $error("pulsed idle");
    spi_start_a: assert property (
        $fell(fs) && !fmt |-> !serial_transmit_line_oe_n && busy) else $error("spi start");
    frame_pulse_a: assert property (
        $fell(fs) && fmt && busy |-> hi_q == (hp << 1)) else $error("pulse width");
    pulsed_msb_a: assert property (
        $fell(fs) && fmt && busy |-> $rose(sc) && !serial_transmit_line_oe_n) else $error("msb");
    clock_rate_a: assert property (
        $changed(sc) && busy && $past(busy) |-> age_q >= hp) else $error("clock too fast");
    select_gap_a: assert property (
        $fell(fs) && !fmt && !clock_phase_bit |-> hi_q > hp) else $error("no select gap");
    spi_end_a: assert property (
        $rose(fs) && !fmt && busy |-> age_q == (clock_phase_bit ? hp << 1 : hp))
        else $error("select rise late or early");
    rx_pulse_a: assert property (
        rx_valid |-> (fmt || busy) ##1 !rx_valid) else $error("rx pulse");
    cover property (fmt && $fell(fs) && busy);
    cover property (!fmt && clock_phase_bit && rx_valid);
    cover property (!fmt && !clock_phase_bit && $rose(fs) && busy);
endmodule
bind ssf_core ssff_monitor u_mon (.core_clk(core_clk), .rstn(rstn), .master_mode(master_mode),
    .frame_format(frame_format), .clock_polarity_bit(clock_polarity_bit),
    .clock_phase_bit(clock_phase_bit), .clock_prescale_divisor(clock_prescale_divisor),
    .clock_rate_field(clock_rate_field), .rx_valid(rx_valid), .busy(busy),
    .serial_clock_line_o(serial_clock_line_o), .serial_clock_line_oe_n(serial_clock_line_oe_n),
    .frame_select_line_o(frame_select_line_o), .serial_transmit_line_o(serial_transmit_line_o),
    .serial_transmit_line_oe_n(serial_transmit_line_oe_n));
`default_nettype wire

// [test/ssff_peer.sv]
// behavioural serial peripheral on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module ssff_peer (
    input wire logic sclk,
    input wire logic fss,
    input wire logic tx,
    input wire logic fmt,
    input wire logic pol,
    input wire logic pha,
    input wire logic [4:0] nbits,
    input wire logic [15:0] reply,
    output logic rx
);
    logic [15:0] sh = 16'h0000;
    logic [15:0] cap = 16'h0000;
    logic arm = 1'b0;
    int cnt = 99;
    logic [15:0] got_q[$];
    initial rx = 1'b0;
    task automatic take();
        cap = {cap[14:0], tx};
        cnt++;
        if (cnt == nbits)
        begin
            got_q.push_back(cap & ((16'h0001 << nbits) - 16'h0001));
            // released line must not keep the last bit
            rx = ~rx;
            cnt = 99;
        end
    endtask
    always @(negedge fss)
        if (!fmt)
        begin
            sh = reply;
            cnt = 0;
            if (!pha) rx = sh[nbits-1];
        end
    always @(posedge fss)
        if (!fmt) rx = ~rx;
    always @(sclk)
        if (fmt)
        begin
            if (!sclk)
            begin
                if (cnt < nbits) take();
                if (fss) arm = 1'b1;
            end
            else if (arm)
            begin
                arm = 1'b0;
                sh = reply;
                cnt = 0;
                rx = sh[nbits-1];
            end
            else if (cnt < nbits) rx = sh[nbits-1-cnt];
        end
        else if (!fss)
        begin
            if ((sclk != pol) == !pha) take();
            else
            begin
                if (pha && cnt > 16)
                begin
                    sh = reply;
                    cnt = 0;
                end
                if (cnt < nbits) rx = sh[nbits-1-cnt];
            end
        end
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the serial frame sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic port_enable = 1'b0;
    logic master_mode = 1'b1;
    logic frame_format = 1'b1;
    logic clock_polarity_bit = 1'b0;
    logic clock_phase_bit = 1'b0;
    logic [3:0] word_size_m1 = 4'h7;
    // half period of three clocks at least, to cover the receive synchroniser
    logic [7:0] clock_prescale_divisor = 8'h06;
    logic [7:0] clock_rate_field = 8'h00;
    logic [15:0] tx_data = 16'h0000;
    logic tx_valid = 1'b0;
    logic [15:0] reply = 16'h6B2D;
    wire tx_ready, rx_valid, busy, sclk, sclk_oe_n, fss, tx, tx_oe_n, rx;
    wire [15:0] rx_data;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int falls = 0;
    logic [15:0] rxq[$];
    ssf_core u_ssf_core (.core_clk(core_clk), .rstn(rstn), .port_enable(port_enable),
        .master_mode(master_mode), .frame_format(frame_format),
        .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit),
        .word_size_m1(word_size_m1), .clock_prescale_divisor(clock_prescale_divisor),
        .clock_rate_field(clock_rate_field), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy),
        .serial_clock_line_o(sclk), .serial_clock_line_oe_n(sclk_oe_n),
        .frame_select_line_o(fss), .serial_transmit_line_o(tx),
        .serial_transmit_line_oe_n(tx_oe_n), .serial_receive_line_i(rx));
    ssff_peer u_ssff_peer (.sclk(sclk), .fss(fss), .tx(tx), .fmt(frame_format),
        .pol(clock_polarity_bit), .pha(clock_phase_bit),
        .nbits({1'b0, word_size_m1} + 5'h01), .reply(reply), .rx(rx));
    initial forever #2.5 core_clk = ~core_clk;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // valid stays up between words; caller lowers it after the last one
    task automatic push(input logic [15:0] w);
        tx_data = w;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
    endtask
    // config changes only while disabled and idle, as the sequencer expects
    task automatic run_mode(input logic f, input logic p, input logic h, input logic [3:0] m1,
        input logic [7:0] r);
        logic [15:0] msk;
        int k;
        msk = 16'hFFFF >> (4'hF - m1);
        port_enable = 1'b0;
        frame_format = f;
        clock_polarity_bit = p;
        clock_phase_bit = h;
        word_size_m1 = m1;
        clock_rate_field = r;
        repeat (4) @(negedge core_clk);
        rxq.delete();
        u_ssff_peer.got_q.delete();
        falls = 0;
        for (k = 0; k < 4; k++) push(16'hA5C3 ^ (16'h1111 * 16'(k)));
        tx_valid = 1'b0;
        repeat (3) @(negedge core_clk);
        check("full fifo refuses", {tx_ready, busy}, 16'h0000);
        port_enable = 1'b1;
        k = 0;
        while ((rxq.size() < 4 || busy !== 1'b0) && k < 4000)
        begin
            @(negedge core_clk);
            k++;
        end
        check("frame done in time", {15'h0000, k < 4000}, 16'h0001);
        check("words sent", 16'(u_ssff_peer.got_q.size()), 16'h0004);
        for (k = 0; k < 4; k++)
        begin
            check("sent word", u_ssff_peer.got_q[k], (16'hA5C3 ^ (16'h1111 * 16'(k))) & msk);
            check("received word", rxq[k], reply & msk);
        end
        check("select falls", 16'(falls), (!f && h) ? 16'h0001 : 16'h0004);
        repeat (2) @(negedge core_clk);
        check("idle clock", sclk, f ? 16'h0000 : {15'h0000, p});
        check("idle select", fss, {15'h0000, !f});
        check(f ? "idle tx enable" : "idle tx", f ? tx_oe_n : tx, {15'h0000, f});
    endtask
    // read mid-cycle, away from the edge that moves the outputs
    always @(negedge core_clk)
    begin
        cyc++;
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    always @(negedge fss) falls++;
    initial
    begin
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        repeat (2) @(negedge core_clk);
        check("clock pad as master", sclk_oe_n, 16'h0000);
        run_mode(1'b1, 1'b0, 1'b0, 4'h7, 8'h00);
        run_mode(1'b0, 1'b0, 1'b0, 4'h3, 8'h01);
        run_mode(1'b0, 1'b0, 1'b1, 4'hF, 8'h00);
        run_mode(1'b0, 1'b1, 1'b0, 4'h9, 8'h00);
        run_mode(1'b0, 1'b1, 1'b1, 4'hB, 8'h01);
        run_mode(1'b1, 1'b0, 1'b0, 4'hF, 8'h01);
        master_mode = 1'b0;
        falls = 0;
        push(16'h3C3C);
        tx_valid = 1'b0;
        repeat (20) @(negedge core_clk);
        check("clock pad as slave", sclk_oe_n, 16'h0001);
        check("slave starts nothing", {busy, 15'(falls)}, 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
